// ### rtl/wkpm_defs.svh
`ifndef WKPM_DEFS_SVH
`define WKPM_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define WKPM_PMC_OFS 8'h00
`define WKPM_HMW_OFS 8'h04
`define WKPM_PIM_OFS 8'h08
`define WKPM_PIS_OFS 8'h0c
`define WKPM_STS_OFS 8'h10
`define WKPM_CLR_OFS 8'h14
`define WKPM_EN_OFS 8'h18
`define WKPM_ICFG_OFS 8'h1c

// ----------------------------------------
// power_mgmt_control fields
// ----------------------------------------
`define WKPM_PMC_OE 0
`define WKPM_PMC_POL 1
`define WKPM_PMC_PULSE 2
`define WKPM_PMC_TYPE 3
`define WKPM_PMC_LAN_STS 4
`define WKPM_PMC_P1_STS 5
`define WKPM_PMC_P2_STS 6
`define WKPM_PMC_LAN_EN 8
`define WKPM_PMC_P1_EN 9
`define WKPM_PMC_P2_EN 10
`define WKPM_PMC_P1_GPD 12
`define WKPM_PMC_P2_GPD 13
`define WKPM_PMC_P1_EDPD 14
`define WKPM_PMC_P2_EDPD 15
`define WKPM_PMC_WMASK 16'hf70f

// ----------------------------------------
// host_mac_wake_ctrl_status fields
// ----------------------------------------
`define WKPM_HMW_MAGIC_PACKET_DETECT_ENABLE 1
`define WKPM_HMW_WAKE_FRAME_DETECT_ENABLE 2
`define WKPM_HMW_WAKE_FRAME_RECEIVED 5
`define WKPM_HMW_MPR 6

// ----------------------------------------
// phy irq mask / source, top status, irq cfg
// ----------------------------------------
`define WKPM_PHY1_ENERGY 7
`define WKPM_PHY2_ENERGY 15
`define WKPM_STS_WAKE 17
`define WKPM_STS_PHY1 26
`define WKPM_STS_PHY2 27
`define WKPM_STS_MASK 32'h0c020000
`define WKPM_ICFG_TYPE 0
`define WKPM_ICFG_POL 4
`define WKPM_ICFG_EN 8
`define WKPM_ICFG_MASK 9'h111
`define WKPM_RST_VAL 32'h00000000

// ----------------------------------------
// timing
// ----------------------------------------
`define WKPM_PULSE_MS 50
`define WKPM_CLK_KHZ 50000
`define WKPM_PULSE_CYC (`WKPM_PULSE_MS * `WKPM_CLK_KHZ)

`endif

// ### rtl/wkpm_pkg.sv
package wkpm_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_pulse = 2'b01,
        st_hold = 2'b11
    } wkpm_state_t;
endpackage : wkpm_pkg

// ### rtl/wkpm_sync2.sv
`timescale 1ns/1ps
module wkpm_sync2 (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic din,
    output logic dout
);
    logic meta_ff;
    logic sync_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end
    assign dout = sync_ff;
endmodule : wkpm_sync2

// ### rtl/wkpm_top.sv
// Contract
// - latch phy1, phy2 energy and lan wake status
// - and statuses with enables, or into wake status
// - wake output needs wake status and output enable
// - wake drive open-drain, push-pull high or low
// - wake output continuous or one 50 ms pulse
// - unmasked cable energy raises that phy interrupt
// - phy2 irq at bit 27, phy1 at 26
// - phy energy wakes when that phy's enable set
// - mac sets received flags when detection enabled
// - either received flag sets lan wake status
// - wake frame or magic packet reaches host irq
// - energy on cable ends energy-detect power-down
// - general power-down entered and left by software
// - every source maskable onto one host irq
// - host irq may be open-drain for sharing
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "wkpm_defs.svh"
module wkpm_top #(
    parameter int PULSE_CYCLES = `WKPM_PULSE_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic phy1_cable_energy_seen,
    input wire logic phy2_cable_energy_seen,
    input wire logic wake_frame_seen,
    input wire logic magic_packet_seen,
    output logic wake_output,
    output logic wake_output_oe,
    output logic host_irq,
    output logic host_irq_oe,
    output logic phy1_power_down,
    output logic phy2_power_down
);
    localparam int CW = 22;

    // ----------------------------------------
    // ahb-lite slave: writes zero wait, reads one wait
    // ----------------------------------------
    logic wr_ff;
    logic rd_ff;
    logic [7:0] addr_ff;
    logic ready_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rd_mux;
    wire addr_ph = hsel & htrans[1] & hready;
    wire rd_req = addr_ph & ~hwrite;
    wire wr_req = addr_ph & hwrite;
    wire wr_pmc = wr_ff & (addr_ff == `WKPM_PMC_OFS);
    wire wr_hmw = wr_ff & (addr_ff == `WKPM_HMW_OFS);
    wire wr_pim = wr_ff & (addr_ff == `WKPM_PIM_OFS);
    wire wr_pis = wr_ff & (addr_ff == `WKPM_PIS_OFS);
    wire wr_clr = wr_ff & (addr_ff == `WKPM_CLR_OFS);
    wire wr_en = wr_ff & (addr_ff == `WKPM_EN_OFS);
    wire wr_icfg = wr_ff & (addr_ff == `WKPM_ICFG_OFS);

    // the read wait state lets a write just before it land first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ff <= 8'h00;
            ready_ff <= 1'b1;
            rdata_ff <= `WKPM_RST_VAL;
        end else begin
            wr_ff <= wr_req;
            rd_ff <= rd_req;
            ready_ff <= ~rd_req;
            if (addr_ph) begin
                addr_ff <= haddr[7:0];
            end
            if (rd_ff) begin
                rdata_ff <= rd_mux;
            end
        end
    end
    assign hrdata = rdata_ff;
    assign hreadyout = ready_ff;
    assign hresp = 1'b0;

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [15:0] pmc_ff;
    logic [1:0] hmw_en_ff;
    logic [1:0] pmask_ff;
    logic [31:0] irq_en_ff;
    logic [8:0] icfg_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pmc_ff <= 16'h0000;
            hmw_en_ff <= 2'h0;
            pmask_ff <= 2'h0;
            irq_en_ff <= `WKPM_RST_VAL;
            icfg_ff <= 9'h000;
        end else begin
            if (wr_pmc) begin
                pmc_ff <= hwdata[15:0] & `WKPM_PMC_WMASK;
            end
            if (wr_hmw) begin
                hmw_en_ff <= {hwdata[`WKPM_HMW_WAKE_FRAME_DETECT_ENABLE],
                              hwdata[`WKPM_HMW_MAGIC_PACKET_DETECT_ENABLE]};
            end
            if (wr_pim) begin
                pmask_ff <= {hwdata[`WKPM_PHY2_ENERGY],
                             hwdata[`WKPM_PHY1_ENERGY]};
            end
            if (wr_en) begin
                irq_en_ff <= hwdata & `WKPM_STS_MASK;
            end
            if (wr_icfg) begin
                icfg_ff <= hwdata[8:0] & `WKPM_ICFG_MASK;
            end
        end
    end
    wire [1:0] ed_en = {pmc_ff[`WKPM_PMC_P2_EN], pmc_ff[`WKPM_PMC_P1_EN]};
    wire [1:0] gpd = {pmc_ff[`WKPM_PMC_P2_GPD], pmc_ff[`WKPM_PMC_P1_GPD]};
    wire [1:0] edpd = {pmc_ff[`WKPM_PMC_P2_EDPD],
                       pmc_ff[`WKPM_PMC_P1_EDPD]};

    // ----------------------------------------
    // phy energy events and power-down
    // ----------------------------------------
    logic [1:0] energy;
    logic [1:0] energy_d_ff;
    logic [1:0] ed_sts_ff;
    logic [1:0] psrc_ff;
    logic [1:0] pd_ff;
    wkpm_sync2 u_sync_p1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(phy1_cable_energy_seen),
        .dout(energy[0])
    );
    wkpm_sync2 u_sync_p2 (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(phy2_cable_energy_seen),
        .dout(energy[1])
    );
    wire [1:0] energy_rise = energy & ~energy_d_ff;
    wire [1:0] ed_w1c = wr_pmc ? {hwdata[`WKPM_PMC_P2_STS],
                                  hwdata[`WKPM_PMC_P1_STS]} : 2'h0;
    wire [1:0] psrc_w1c = wr_pis ? {hwdata[`WKPM_PHY2_ENERGY],
                                    hwdata[`WKPM_PHY1_ENERGY]} : 2'h0;
    // set wins over clear so an event in the clearing cycle stays
    wire [1:0] nxt_ed_sts = energy_rise | (ed_sts_ff & ~ed_w1c);
    wire [1:0] nxt_psrc = energy_rise | (psrc_ff & ~psrc_w1c);
    wire [1:0] phy_irq = psrc_ff & pmask_ff;
    // edpd only wakes while energy lasts; gpd never self-clears
    wire [1:0] nxt_pd = gpd | (edpd & ~energy);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            energy_d_ff <= 2'h0;
            ed_sts_ff <= 2'h0;
            psrc_ff <= 2'h0;
            pd_ff <= 2'h0;
        end else begin
            energy_d_ff <= energy;
            ed_sts_ff <= nxt_ed_sts;
            psrc_ff <= nxt_psrc;
            pd_ff <= nxt_pd;
        end
    end
    assign phy1_power_down = pd_ff[0];
    assign phy2_power_down = pd_ff[1];

    // ----------------------------------------
    // host mac wake detection
    // ----------------------------------------
    logic wake_frame_received_ff;
    logic mpr_ff;
    logic lan_sts_ff;
    wire wake_frame_received_w1c = wr_hmw & hwdata[`WKPM_HMW_WAKE_FRAME_RECEIVED];
    wire mpr_w1c = wr_hmw & hwdata[`WKPM_HMW_MPR];
    wire lan_w1c = wr_pmc & hwdata[`WKPM_PMC_LAN_STS];
    wire nxt_wake_frame_received = (wake_frame_seen & hmw_en_ff[1]) |
                    (wake_frame_received_ff & ~wake_frame_received_w1c);
    wire nxt_mpr = (magic_packet_seen & hmw_en_ff[0]) |
                   (mpr_ff & ~mpr_w1c);
    wire nxt_lan_sts = wake_frame_received_ff | mpr_ff | (lan_sts_ff & ~lan_w1c);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_frame_received_ff <= 1'b0;
            mpr_ff <= 1'b0;
            lan_sts_ff <= 1'b0;
        end else begin
            wake_frame_received_ff <= nxt_wake_frame_received;
            mpr_ff <= nxt_mpr;
            lan_sts_ff <= nxt_lan_sts;
        end
    end

    // ----------------------------------------
    // wake status and top-level interrupt
    // ----------------------------------------
    logic [31:0] sts_ff;
    logic irq_ff;
    logic irq_oe_ff;
    wire wake_irq_status = |({lan_sts_ff, ed_sts_ff} &
                             {pmc_ff[`WKPM_PMC_LAN_EN], ed_en});
    wire [31:0] sts_src = {4'h0, phy_irq[1], phy_irq[0], 8'h00,
                           wake_irq_status, 17'h00000};
    wire [31:0] sts_clr = wr_clr ? hwdata : 32'h00000000;
    // a source still pending sets its bit again after a clear
    wire [31:0] nxt_sts = sts_src | (sts_ff & ~sts_clr);
    wire irq_act = (|(sts_ff & irq_en_ff)) & icfg_ff[`WKPM_ICFG_EN];
    wire irq_pp = icfg_ff[`WKPM_ICFG_TYPE];
    wire nxt_irq = irq_pp & (irq_act == icfg_ff[`WKPM_ICFG_POL]);
    wire nxt_irq_oe = irq_pp | irq_act;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sts_ff <= `WKPM_RST_VAL;
            irq_ff <= 1'b0;
            irq_oe_ff <= 1'b0;
        end else begin
            sts_ff <= nxt_sts;
            irq_ff <= nxt_irq;
            irq_oe_ff <= nxt_irq_oe;
        end
    end
    assign host_irq = irq_ff;
    assign host_irq_oe = irq_oe_ff;

    // ----------------------------------------
    // wake output conditioning
    // ----------------------------------------
    wkpm_pkg::wkpm_state_t state_ff;
    wkpm_pkg::wkpm_state_t nxt_state;
    logic [CW-1:0] cnt_ff;
    logic gated_d_ff;
    logic wake_ff;
    logic wake_oe_ff;
    wire gated = wake_irq_status & pmc_ff[`WKPM_PMC_OE];
    wire gated_rise = gated & ~gated_d_ff;
    wire pulse_sel = pmc_ff[`WKPM_PMC_PULSE];
    wire cnt_done = (cnt_ff == {CW{1'b0}});
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            wkpm_pkg::st_idle: begin
                if (pulse_sel && gated_rise) begin
                    nxt_state = wkpm_pkg::st_pulse;
                end
            end
            wkpm_pkg::st_pulse: begin
                if (cnt_done) begin
                    nxt_state = gated ? wkpm_pkg::st_hold
                                      : wkpm_pkg::st_idle;
                end
            end
            wkpm_pkg::st_hold: begin
                if (!gated) begin
                    nxt_state = wkpm_pkg::st_idle;
                end
            end
            default: begin
                nxt_state = wkpm_pkg::st_idle;
            end
        endcase
    end
    wire load = (state_ff == wkpm_pkg::st_idle) && pulse_sel && gated_rise;
    // a long pulse costs a 22-bit counter instead of a prescaler
    wire [CW-1:0] nxt_cnt = load ? CW'(PULSE_CYCLES - 1) :
                            cnt_done ? cnt_ff : cnt_ff - 1'b1;
    wire wake_act = (nxt_state == wkpm_pkg::st_pulse) |
                    (~pulse_sel & gated);
    wire wake_pp = pmc_ff[`WKPM_PMC_TYPE];
    wire nxt_wake = wake_pp & (wake_act == pmc_ff[`WKPM_PMC_POL]);
    wire nxt_wake_oe = wake_pp | wake_act;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= wkpm_pkg::st_idle;
            cnt_ff <= {CW{1'b0}};
            gated_d_ff <= 1'b0;
            wake_ff <= 1'b0;
            wake_oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            gated_d_ff <= gated;
            wake_ff <= nxt_wake;
            wake_oe_ff <= nxt_wake_oe;
        end
    end
    assign wake_output = wake_ff;
    assign wake_output_oe = wake_oe_ff;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire [31:0] pmc_rd = {16'h0000, pmc_ff} |
                         {25'h0, ed_sts_ff, lan_sts_ff, 4'h0};
    wire [31:0] hmw_rd = {25'h0, mpr_ff, wake_frame_received_ff, 2'h0, hmw_en_ff, 1'b0};
    wire [31:0] pim_rd = {16'h0, pmask_ff[1], 7'h0, pmask_ff[0], 7'h0};
    wire [31:0] pis_rd = {16'h0, psrc_ff[1], 7'h0, psrc_ff[0], 7'h0};
    assign rd_mux = (addr_ff == `WKPM_PMC_OFS) ? pmc_rd :
                    (addr_ff == `WKPM_HMW_OFS) ? hmw_rd :
                    (addr_ff == `WKPM_PIM_OFS) ? pim_rd :
                    (addr_ff == `WKPM_PIS_OFS) ? pis_rd :
                    (addr_ff == `WKPM_STS_OFS) ? sts_ff :
                    (addr_ff == `WKPM_EN_OFS) ? irq_en_ff :
                    (addr_ff == `WKPM_ICFG_OFS) ? {23'h0, icfg_ff} :
                    32'h00000000;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ed_latch;
        energy_rise[0] |=> ed_sts_ff[0] && psrc_ff[0];
    endproperty
    a_ed_latch: assert property (p_ed_latch)
        else $error("phy1 energy event not latched");

    property p_wake_sts;
        (lan_sts_ff && pmc_ff[`WKPM_PMC_LAN_EN]) |=> sts_ff[`WKPM_STS_WAKE];
    endproperty
    a_wake_sts: assert property (p_wake_sts)
        else $error("lan wake not in wake status");

    property p_no_wake;
        !pmc_ff[`WKPM_PMC_OE] && $stable(pmc_ff) && wake_pp
            && state_ff == wkpm_pkg::st_idle
            |=> wake_ff != pmc_ff[`WKPM_PMC_POL];
    endproperty
    a_no_wake: assert property (p_no_wake)
        else $error("wake driven without output enable");

    property p_od;
        !wake_pp |=> !wake_ff;
    endproperty
    a_od: assert property (p_od)
        else $error("open-drain wake drove high");

    sequence s_start;
        state_ff == wkpm_pkg::st_idle && load;
    endsequence
    sequence s_counting;
        state_ff == wkpm_pkg::st_pulse && wake_oe_ff;
    endsequence
    property p_pulse;
        s_start |=> s_counting ##1 (cnt_ff == CW'(PULSE_CYCLES - 2));
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("wake pulse did not start counting");

    property p_phy_irq;
        energy_rise[1] && pmask_ff[1] |=> ##1 sts_ff[`WKPM_STS_PHY2];
    endproperty
    a_phy_irq: assert property (p_phy_irq)
        else $error("phy2 energy interrupt missing");

    // config must hold through the cycle that drives the pin
    property p_ed_wake;
        energy_rise[0] && ed_en[0] && pmc_ff[`WKPM_PMC_OE] && !pulse_sel
            && $stable(pmc_ff) ##1 $stable(pmc_ff) ##1 $stable(pmc_ff)
            |-> wake_oe_ff;
    endproperty
    a_ed_wake: assert property (p_ed_wake)
        else $error("energy wake not asserted");

    property p_mp;
        magic_packet_seen && hmw_en_ff[0] |=> mpr_ff ##1 lan_sts_ff;
    endproperty
    a_mp: assert property (p_mp)
        else $error("magic packet not flagged");

    property p_irq;
        irq_act && !irq_pp |=> irq_oe_ff && !irq_ff;
    endproperty
    a_irq: assert property (p_irq)
        else $error("open-drain irq not pulled");

    property p_pd;
        gpd[0] |=> phy1_power_down;
    endproperty
    a_pd: assert property (p_pd)
        else $error("general power-down not applied");
endmodule : wkpm_top

// ### test/wkpm_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host power controller and irq line
// ----------------------------------------
module wkpm_host_model (
    input wire logic wake_output,
    input wire logic wake_output_oe,
    input wire logic host_irq,
    input wire logic host_irq_oe,
    output logic wake_line,
    output logic irq_line
);
    // board pull-ups: a released open-drain line reads high, never stale
    assign wake_line = wake_output_oe ? wake_output : 1'b1;
    assign irq_line = host_irq_oe ? host_irq : 1'b1;
endmodule : wkpm_host_model

// ### test/tb_wkpm_top.sv
`timescale 1ns/1ps
`include "wkpm_defs.svh"
module tb_wkpm_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic p1_en = 1'b0;
    logic p2_en = 1'b0;
    logic wf = 1'b0;
    logic mp = 1'b0;
    logic wake_output, wake_output_oe, host_irq, host_irq_oe;
    logic p1_pd, p2_pd, wake_line, irq_line;
    int errors = 0;
    int checks_done = 0;
    int cnt;

    initial begin
        forever #10 hclk = ~hclk;
    end

    // single slave: its ready is the bus ready
    wkpm_top #(.PULSE_CYCLES(20)) dut_u (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .phy1_cable_energy_seen(p1_en), .phy2_cable_energy_seen(p2_en),
        .wake_frame_seen(wf), .magic_packet_seen(mp),
        .wake_output(wake_output), .wake_output_oe(wake_output_oe),
        .host_irq(host_irq), .host_irq_oe(host_irq_oe),
        .phy1_power_down(p1_pd), .phy2_power_down(p2_pd));

    wkpm_host_model host_u (.wake_output(wake_output),
        .wake_output_oe(wake_output_oe), .host_irq(host_irq),
        .host_irq_oe(host_irq_oe), .wake_line(wake_line),
        .irq_line(irq_line));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic finish_test;
        if (errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        // ready is sampled at the edge, so a stall never drops the data
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        rd = hrdata;
        if (n >= 50) begin
            errors++;
            $display("[ERR] %0t bus hang", $time);
            finish_test();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(1'b1, a, d, t);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk(d & m, e);
    endtask : rc

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        idle(4);
        chk({30'h0, hreadyout, wake_output}, 32'h2);
        hresetn <= 1'b1;
        idle(1);
        rc(`WKPM_PMC_OFS, 32'hffffffff, 32'h0);
        wr(8'h40, 32'hffffffff);
        rc(8'h40, 32'hffffffff, 32'h0);
        wr(`WKPM_STS_OFS, 32'hffffffff);
        rc(`WKPM_STS_OFS, 32'hffffffff, 32'h0);
        wr(`WKPM_CLR_OFS, 32'hffffffff);
        rc(`WKPM_CLR_OFS, 32'hffffffff, 32'h0);
        // detection off: a magic packet leaves no trace
        mp <= 1'b1;
        idle(1);
        mp <= 1'b0;
        idle(5);
        rc(`WKPM_HMW_OFS, 32'h60, 32'h0);
        rc(`WKPM_PMC_OFS, 32'h10, 32'h0);
        wr(`WKPM_HMW_OFS, 32'h2);
        wr(`WKPM_PMC_OFS, 32'h10b);
        wr(`WKPM_EN_OFS, 32'h00020000);
        wr(`WKPM_ICFG_OFS, 32'h111);
        mp <= 1'b1;
        idle(1);
        mp <= 1'b0;
        idle(8);
        rc(`WKPM_HMW_OFS, 32'h60, 32'h40);
        rc(`WKPM_PMC_OFS, 32'hffffffff, 32'h11b);
        rc(`WKPM_STS_OFS, 32'h00020000, 32'h00020000);
        chk({30'h0, wake_output_oe, wake_line}, 32'h3);
        chk({30'h0, host_irq_oe, host_irq}, 32'h3);
        wr(`WKPM_EN_OFS, 32'h0);
        idle(3);
        chk({31'h0, host_irq}, 32'h0);
        wr(`WKPM_EN_OFS, 32'h00020000);
        wr(`WKPM_PMC_OFS, 32'h10a);
        idle(3);
        chk({30'h0, wake_output_oe, wake_output}, 32'h2);
        // clear the source first, else the status re-sets
        wr(`WKPM_HMW_OFS, 32'h42);
        wr(`WKPM_PMC_OFS, 32'h11a);
        wr(`WKPM_CLR_OFS, 32'h00020000);
        idle(3);
        rc(`WKPM_STS_OFS, 32'hffffffff, 32'h0);
        chk({31'h0, host_irq}, 32'h0);
        wr(`WKPM_HMW_OFS, 32'h4);
        wf <= 1'b1;
        idle(1);
        wf <= 1'b0;
        idle(8);
        rc(`WKPM_HMW_OFS, 32'h60, 32'h20);
        rc(`WKPM_PMC_OFS, 32'h10, 32'h10);
        // pulse mode: exactly one pulse of the set width
        wr(`WKPM_PMC_OFS, 32'h10f);
        cnt = 0;
        repeat (40) begin
            @(posedge hclk);
            if (wake_output === 1'b1) cnt++;
        end
        chk(32'(cnt), 32'h14);
        wr(`WKPM_HMW_OFS, 32'h20);
        wr(`WKPM_PMC_OFS, 32'h10);
        wr(`WKPM_CLR_OFS, 32'h00020000);
        // phy energy, open-drain wake
        wr(`WKPM_PIM_OFS, 32'h80);
        wr(`WKPM_EN_OFS, 32'h0c020000);
        wr(`WKPM_PMC_OFS, 32'h201);
        p1_en <= 1'b1;
        idle(10);
        rc(`WKPM_PIS_OFS, 32'h8080, 32'h80);
        rc(`WKPM_STS_OFS, 32'h0c020000, 32'h04020000);
        rc(`WKPM_PMC_OFS, 32'h60, 32'h20);
        chk({30'h0, wake_output_oe, wake_output}, 32'h2);
        chk({31'h0, wake_line}, 32'h0);
        chk({31'h0, host_irq}, 32'h1);
        wr(`WKPM_ICFG_OFS, 32'h100);
        idle(3);
        chk({30'h0, host_irq_oe, irq_line}, 32'h2);
        p2_en <= 1'b1;
        idle(10);
        rc(`WKPM_STS_OFS, 32'h08000000, 32'h0);
        p2_en <= 1'b0;
        idle(6);
        wr(`WKPM_PIM_OFS, 32'h8080);
        p2_en <= 1'b1;
        idle(10);
        rc(`WKPM_STS_OFS, 32'h08000000, 32'h08000000);
        rc(`WKPM_PMC_OFS, 32'h60, 32'h60);
        wr(`WKPM_PMC_OFS, 32'h209);
        idle(3);
        chk({30'h0, wake_output_oe, wake_output}, 32'h2);
        wr(`WKPM_PMC_OFS, 32'h208);
        idle(3);
        chk({30'h0, wake_output_oe, wake_output}, 32'h3);
        // power-down modes
        wr(`WKPM_PMC_OFS, 32'h1000);
        idle(3);
        chk({30'h0, p2_pd, p1_pd}, 32'h1);
        wr(`WKPM_PMC_OFS, 32'h8000);
        idle(3);
        chk({30'h0, p2_pd, p1_pd}, 32'h0);
        p2_en <= 1'b0;
        idle(6);
        chk({30'h0, p2_pd, p1_pd}, 32'h2);
        p2_en <= 1'b1;
        idle(6);
        chk({30'h0, p2_pd, p1_pd}, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        finish_test();
    end
endmodule : tb_wkpm_top
